// ---- rtl/wdsw_pkg.sv ----
// package: constants and types for the watchdog / sleep-wake controller
package wdsw_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] WDSW_ADDR_WDCTL  = 8'h00;
  localparam logic [7:0] WDSW_ADDR_OPTION = 8'h04;
  localparam logic [7:0] WDSW_ADDR_STATUS = 8'h08;
  localparam logic [7:0] WDSW_ADDR_CMD    = 8'h0C;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int         WDSW_EN_BIT      = 0;
  localparam int         WDSW_PS_LSB      = 1;
  localparam int         WDSW_PS_W        = 4;
  localparam logic [4:0] WDSW_WDCTL_RST   = 5'h08;
  localparam logic [7:0] WDSW_OPTION_RST  = 8'hFF;
  localparam logic [3:0] WDSW_PS_MAX      = 4'hB;
  localparam int         WDSW_BASE_LOG2   = 5;
  localparam int         WDSW_CNT_W       = 17;
  localparam logic [15:0] WDSW_INT_VECTOR = 16'h0004;

  // command register bits
  localparam int         WDSW_CMD_SLEEP   = 0;
  localparam int         WDSW_CMD_CLRWDT  = 1;

  // status register bits
  localparam int         WDSW_ST_PD       = 0;
  localparam int         WDSW_ST_TO       = 1;
  localparam int         WDSW_ST_ASLEEP   = 2;

  localparam logic [1:0] WDSW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WDSW_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WDSW_RUN,
    WDSW_SLEEP,
    WDSW_WAKE
  } wdsw_state_t;

endpackage

// ---- rtl/wdsw_top.sv ----
// watchdog timer with sleep entry and wake-up sequencing
`timescale 1ns/1ns
module wdsw_top
  import wdsw_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // axi4-lite write address / data / response
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // configuration and pins
  input  wire logic                 configWatchdogEnable,
  input  wire logic                 masterClearInput_n,
  // core side
  input  wire logic                 sleepExec,
  input  wire logic                 globalInterruptEnable,
  input  wire logic [NUM_IRQ-1:0]   irqEnable,
  input  wire logic [NUM_IRQ-1:0]   irqFlag,
  input  wire logic [NUM_IRQ-1:0]   irqSleepCapable,
  input  wire logic                 timerOneAsync,
  input  wire logic                 adcOnInternalRc,
  input  wire logic                 timerOneIrq,
  input  wire logic                 adcDoneIrq,
  // status outputs
  output logic                      powerDownFlag,
  output logic                      timeoutFlag,
  output logic                      oscDriverOn,
  output logic                      portHold,
  output logic                      coreResume,
  output logic                      prefetchNext,
  output logic                      branchVector,
  output logic                      watchdogResetReq,
  output logic                      masterClearResetReq
);

  // ****************************************
  // parameter checks
  // ****************************************
  if (NUM_IRQ < 1 || NUM_IRQ > 24) begin : g_chk
    $error("NUM_IRQ must be 1..24");
  end

  function automatic logic [WDSW_CNT_W-1:0] psLimit(input logic [3:0] code);
    logic [WDSW_CNT_W-1:0] one;
    one = {{(WDSW_CNT_W-1){1'b0}}, 1'b1};
    psLimit = (one << (WDSW_BASE_LOG2 + int'(code))) - one;
  endfunction

  // ****************************************
  // master clear pin synchroniser
  // ****************************************
  logic mclrS1_r, mclrS2_r, mclrS3_r, mclrLow_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mclrS1_r <= 1'b1;
      mclrS2_r <= 1'b1;
      mclrS3_r <= 1'b1;
      mclrLow_r <= 1'b0;
    end else begin
      mclrS1_r <= masterClearInput_n;
      mclrS2_r <= mclrS1_r;
      mclrS3_r <= mclrS2_r;
      // a glitch shorter than two cycles never reaches the reset logic
      if (mclrS2_r == mclrS3_r) begin
        mclrLow_r <= !mclrS3_r;
      end
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic [4:0]  wdCtl_r;
  logic [7:0]  option_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic        awHave_r, wHave_r;
  logic        wrFire, cmdSleep, cmdClrWdt;
  logic        mclrRst;

  // a master clear acts as a device reset on everything but the pin logic, the axi4-lite slave and the core-facing output registers
  assign mclrRst = mclrLow_r;
  // an open response holds off the next write until the master takes it
  assign wrFire  = awHave_r && wHave_r && !s_axi_bvalid;
  assign cmdSleep  = wrFire && awAddr_r == WDSW_ADDR_CMD && wData_r[WDSW_CMD_SLEEP];
  assign cmdClrWdt = wrFire && awAddr_r == WDSW_ADDR_CMD && wData_r[WDSW_CMD_CLRWDT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= WDSW_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHave_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
      end
      if (wrFire) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r <= WDSW_ADDR_CMD) ? WDSW_RESP_OKAY : WDSW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; a watchdog reset also restores them
  logic wdReset_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdCtl_r <= WDSW_WDCTL_RST;
      option_r <= WDSW_OPTION_RST;
    end else if (mclrRst || wdReset_r) begin
      wdCtl_r <= WDSW_WDCTL_RST;
      option_r <= WDSW_OPTION_RST;
    end else if (wrFire && s_axi_wstrb[0]) begin
      // only byte lane 0 carries implemented bits
      if (awAddr_r == WDSW_ADDR_WDCTL) begin
        wdCtl_r <= wData_r[4:0];
      end
      if (awAddr_r == WDSW_ADDR_OPTION) begin
        option_r <= wData_r[7:0];
      end
    end
  end

  // ****************************************
  // watchdog counter
  // ****************************************
  logic        wdEnabled, wdExpire, psValid;
  logic [WDSW_CNT_W-1:0] wdCnt_r;
  wdsw_state_t state_r;
  logic        wakeReq, sleepAccept, wakeEvent;

  assign wdEnabled = configWatchdogEnable || wdCtl_r[WDSW_EN_BIT];
  // reserved codes never expire rather than alias a legal period
  assign psValid  = wdCtl_r[WDSW_PS_LSB +: WDSW_PS_W] <= WDSW_PS_MAX;
  assign wdExpire = wdEnabled && psValid &&
                    wdCnt_r == psLimit(wdCtl_r[WDSW_PS_LSB +: WDSW_PS_W]);

  // dropping the enable restarts the count, so re-enabling gives a full period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdCnt_r <= '0;
    end else if (mclrRst || !wdEnabled || wdExpire || cmdClrWdt) begin
      wdCnt_r <= '0;
    end else if (sleepAccept || wakeEvent) begin
      wdCnt_r <= '0;
    end else begin
      wdCnt_r <= wdCnt_r + 1'b1;
    end
  end

  // ****************************************
  // sleep / wake sequencing
  // ****************************************
  logic [NUM_IRQ-1:0] irqWakeCapable;
  logic pendIrq;
  assign irqWakeCapable = irqEnable & irqFlag & irqSleepCapable;
  // enable, flag and sleep-capable mask decide; the global enable is not consulted
  assign pendIrq = (|irqWakeCapable) ||
                   (timerOneIrq && timerOneAsync) ||
                   (adcDoneIrq && adcOnInternalRc);
  assign wakeReq = pendIrq;
  // a wake condition already present turns the sleep into a no-op
  assign sleepAccept = state_r == WDSW_RUN && (sleepExec || cmdSleep) && !wakeReq;
  assign wakeEvent = state_r == WDSW_SLEEP && (pendIrq || wdExpire);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= WDSW_RUN;
    end else if (mclrRst) begin
      state_r <= WDSW_RUN;
    end else begin
      unique case (state_r)
        WDSW_RUN:   if (sleepAccept) state_r <= WDSW_SLEEP;
        WDSW_SLEEP: if (wakeEvent) state_r <= WDSW_WAKE;
        WDSW_WAKE:  state_r <= WDSW_RUN;
        default:    state_r <= WDSW_RUN;
      endcase
    end
  end

  // status flags: power-down set at power-up, both restored by master clear
  // sleep entry outranks a same-cycle expiry so the sleep still completes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerDownFlag <= 1'b1;
      timeoutFlag <= 1'b1;
    end else if (mclrRst) begin
      powerDownFlag <= 1'b1;
      timeoutFlag <= 1'b1;
    end else if (sleepAccept) begin
      powerDownFlag <= 1'b0;
      timeoutFlag <= 1'b1;
    end else if (wdExpire) begin
      timeoutFlag <= 1'b0;
    end else if (cmdClrWdt) begin
      powerDownFlag <= 1'b1;
      timeoutFlag <= 1'b1;
    end
  end

  // core-facing outputs
  // oscillator and port hold share one term so they can never disagree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscDriverOn <= 1'b1;
      portHold <= 1'b0;
      coreResume <= 1'b0;
      prefetchNext <= 1'b0;
      branchVector <= 1'b0;
      watchdogResetReq <= 1'b0;
      wdReset_r <= 1'b0;
      masterClearResetReq <= 1'b0;
    end else begin
      oscDriverOn <= !(sleepAccept || (state_r == WDSW_SLEEP && !wakeEvent));
      portHold <= sleepAccept || (state_r == WDSW_SLEEP && !wakeEvent);
      prefetchNext <= sleepAccept;
      coreResume <= wakeEvent;
      branchVector <= wakeEvent && pendIrq && globalInterruptEnable;
      // awake expiry resets internally; the master clear pin is input only
      watchdogResetReq <= wdExpire && state_r != WDSW_SLEEP && !mclrRst;
      wdReset_r <= wdExpire && state_r != WDSW_SLEEP && !mclrRst;
      masterClearResetReq <= mclrRst;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= WDSW_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= WDSW_RESP_OKAY;
        unique case (s_axi_araddr)
          WDSW_ADDR_WDCTL:  s_axi_rdata <= {27'h0, wdCtl_r};
          WDSW_ADDR_OPTION: s_axi_rdata <= {24'h0, option_r};
          WDSW_ADDR_STATUS: s_axi_rdata <= {29'h0, state_r == WDSW_SLEEP,
                                            timeoutFlag, powerDownFlag};
          WDSW_ADDR_CMD:    s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= WDSW_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_sleep_flags: assert property (@(posedge clk) disable iff (!resetn)
    sleepAccept && !mclrRst |=> !powerDownFlag && timeoutFlag)
    else $error("sleep entry flags wrong");
  a_noop_sleep: assert property (@(posedge clk) disable iff (!resetn)
    state_r == WDSW_RUN && sleepExec && wakeReq && !mclrRst |=> state_r == WDSW_RUN)
    else $error("sleep taken while wake pending");
  a_wake_count: assert property (@(posedge clk) disable iff (!resetn)
    wakeEvent && !mclrRst |=> wdCnt_r == '0)
    else $error("count not cleared on wake");
  a_osc_off: assert property (@(posedge clk) disable iff (!resetn)
    state_r == WDSW_SLEEP && $past(state_r) == WDSW_SLEEP && !$past(wakeEvent)
      |-> !oscDriverOn && portHold)
    else $error("oscillator running in sleep");
  a_wd_forced: assert property (@(posedge clk) disable iff (!resetn)
    configWatchdogEnable |-> wdEnabled)
    else $error("config enable ignored");
  a_sleep_expire: assert property (@(posedge clk) disable iff (!resetn)
    wdExpire && state_r == WDSW_SLEEP |=> !watchdogResetReq ##1 state_r == WDSW_RUN)
    else $error("sleep expiry caused reset");
  a_awake_expire: assert property (@(posedge clk) disable iff (!resetn)
    wdExpire && state_r == WDSW_RUN && !mclrRst |=> watchdogResetReq ##1 wdCtl_r == WDSW_WDCTL_RST)
    else $error("awake expiry missed reset");
  a_vector_ge: assert property (@(posedge clk) disable iff (!resetn)
    wakeEvent && pendIrq && !globalInterruptEnable |=> coreResume && !branchVector)
    else $error("vector taken with global disabled");
  a_prefetch: assert property (@(posedge clk) disable iff (!resetn)
    sleepAccept |=> prefetchNext)
    else $error("no prefetch on sleep");
  a_timeout_clr: assert property (@(posedge clk) disable iff (!resetn)
    wdExpire && !sleepAccept && !mclrRst |=> !timeoutFlag)
    else $error("timeout flag not cleared");
  // master clear overrides the state, counter, flags and control registers, so most properties leave it out
  a_ctl_master_clear_input: assert property (@(posedge clk) disable iff (!resetn)
    mclrRst |=> wdCtl_r == WDSW_WDCTL_RST && option_r == WDSW_OPTION_RST)
    else $error("control not restored by master clear");
  a_master_clear_input_reset: assert property (@(posedge clk) disable iff (!resetn)
    mclrRst |=> masterClearResetReq && state_r == WDSW_RUN)
    else $error("master clear did not reset");
  a_sleep_count: assert property (@(posedge clk) disable iff (!resetn)
    sleepAccept && !mclrRst |=> wdCnt_r == '0 && state_r == WDSW_SLEEP)
    else $error("count not cleared on sleep");
  a_noop_flags: assert property (@(posedge clk) disable iff (!resetn)
    state_r == WDSW_RUN && sleepExec && wakeReq && !mclrRst && !cmdClrWdt
      |=> powerDownFlag == $past(powerDownFlag))
    else $error("no-op sleep changed power-down flag");
  a_wake_resume: assert property (@(posedge clk) disable iff (!resetn)
    wakeEvent && !mclrRst |=> coreResume && !watchdogResetReq)
    else $error("wake did not resume execution");
  a_irq_wake: assert property (@(posedge clk) disable iff (!resetn)
    state_r == WDSW_SLEEP && (|irqWakeCapable) && !mclrRst |=> coreResume)
    else $error("enabled interrupt did not wake");
  a_vector_on: assert property (@(posedge clk) disable iff (!resetn)
    wakeEvent && pendIrq && globalInterruptEnable |=> coreResume && branchVector)
    else $error("vector not taken with global enabled");
  a_osc_back: assert property (@(posedge clk) disable iff (!resetn)
    coreResume |-> oscDriverOn && !portHold)
    else $error("oscillator off after wake");

endmodule

// ---- verification/tb_watchdog_sleep_wake_control.sv ----
// self-checking bench for the watchdog and sleep/wake controller
`timescale 1ns/1ns
module tb_watchdog_sleep_wake_control;
  import wdsw_pkg::*;
  logic clk = 0, resetn = 0, cfgEn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sleepExec, global_interrupt_enable, t1Async, t1Irq, mclrN;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] irqEn, irqFl;
  logic pdFlag, toFlag, oscOn, hold, resume, prefetch, branch, wdRst, mcRst;
  logic sleepReq = 0, gieReq = 0, irqReq = 0, t1Req = 0, t1AReq = 0, clearReq = 0;
  logic adcReq = 0, adcRcReq = 0, adcRc, adcIrq;
  logic [3:0] evs;
  int failures = 0, checks = 0, cycles = 0, wdResets = 0, n, k;
  assign evs = {mcRst, prefetch, wdRst, resume};
  always #4 clk = ~clk;
  always @(negedge clk) if (wdRst === 1'b1) wdResets++;
  wdsw_top u_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .configWatchdogEnable(cfgEn),
    .masterClearInput_n(mclrN), .sleepExec(sleepExec), .globalInterruptEnable(global_interrupt_enable),
    .irqEnable(irqEn), .irqFlag(irqFl), .irqSleepCapable(8'hFF),
    .timerOneAsync(t1Async), .adcOnInternalRc(adcRc), .timerOneIrq(t1Irq),
    .adcDoneIrq(adcIrq), .powerDownFlag(pdFlag), .timeoutFlag(toFlag),
    .oscDriverOn(oscOn), .portHold(hold), .coreResume(resume), .prefetchNext(prefetch),
    .branchVector(branch), .watchdogResetReq(wdRst), .masterClearResetReq(mcRst));
  wdsw_core_model u_core (.clk(clk), .resetn(resetn), .sleepReq(sleepReq),
    .gieReq(gieReq), .irqReq(irqReq), .t1Req(t1Req), .t1AsyncReq(t1AReq),
    .clearReq(clearReq), .sleepExec(sleepExec), .globalInterruptEnable(global_interrupt_enable),
    .irqEnable(irqEn), .irqFlag(irqFl), .timerOneAsync(t1Async),
    .timerOneIrq(t1Irq), .adcReq(adcReq), .adcRcReq(adcRcReq),
    .adcOnInternalRc(adcRc), .adcDoneIrq(adcIrq), .masterClearInput_n(mclrN));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // handshakes are judged just after an edge; ready/valid are registered
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 0;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!b) begin
      #1;
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] a);
    logic ar, r;
    r = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!r) begin
      #1;
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      {rd, rs} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // n = cycles until the event, or lim+1 if it never came
  task automatic waitEv(input int sel, input int lim);
    for (n = 1; n <= lim; n++) begin
      @(posedge clk);
      #1;
      if (evs[sel] === 1'b1) return;
    end
  endtask
  task automatic doSleep;
    @(posedge clk);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    waitEv(2, 6);
    check(n <= 6, 1);
    check({pdFlag, toFlag, oscOn, hold}, 4'b0101);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic tReset;
    axiRead(WDSW_ADDR_WDCTL);
    check(rd, 32'h08);
    axiRead(WDSW_ADDR_OPTION);
    check(rd, 32'hFF);
    axiRead(WDSW_ADDR_STATUS);
    check(rd[2:0], 3'b011);
    axiRead(8'h10);
    check(rd, 32'h0);
    check(rs, WDSW_RESP_SLVERR);
    axiWrite(8'h10, 32'h0);
    check(rs, WDSW_RESP_SLVERR);
  endtask
  task automatic tPeriod;
    axiWrite(WDSW_ADDR_WDCTL, 32'hFF);
    check(rs, WDSW_RESP_OKAY);
    axiRead(WDSW_ADDR_WDCTL);
    check(rd, 32'h1F);
    waitEv(1, 300);
    check(n, 301);
    axiWrite(WDSW_ADDR_WDCTL, 32'h00);
    waitEv(1, 80);
    check(n, 81);
    for (k = 0; k < 3; k++) begin
      axiWrite(WDSW_ADDR_WDCTL, 32'h01 | (k << 1));
      waitEv(1, 200);
      check(n inside {[(32 << k) - 8 : (32 << k) + 2]}, 1);
    end
    axiRead(WDSW_ADDR_STATUS);
    check(rd[1], 1'b0);
    check(mcRst, 1'b0);
  endtask
  task automatic tConfig;
    @(posedge clk);
    cfgEn <= 1'b1;
    axiWrite(WDSW_ADDR_WDCTL, 32'h00);
    waitEv(1, 40);
    check(n <= 40, 1);
    cfgEn <= 1'b0;
  endtask
  task automatic tWdWake;
    axiWrite(WDSW_ADDR_WDCTL, 32'h01);
    k = wdResets;
    doSleep();
    waitEv(0, 40);
    check(n inside {[29:35]}, 1);
    check(branch, 1'b0);
    check(wdResets, k);
    waitEv(1, 40);
    check(n inside {[28:34]}, 1);
    axiRead(WDSW_ADDR_STATUS);
    check(rd[1:0], 2'b00);
  endtask
  task automatic tIrqWake;
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      gieReq <= k[0];
      doSleep();
      waitEv(0, 8);
      check(n, 9);
      irqReq <= 1'b1;
      waitEv(0, 6);
      check(n <= 6, 1);
      check(branch, k[0]);
      check({oscOn, hold}, 2'b10);
      @(posedge clk);
      irqReq <= 1'b0;
    end
  endtask
  task automatic tPending;
    axiWrite(WDSW_ADDR_CMD, 32'h02);
    irqReq <= 1'b1;
    repeat (3) @(posedge clk);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    waitEv(2, 6);
    check({n[7:0], pdFlag, oscOn}, {8'd7, 2'b11});
    irqReq <= 1'b0;
  endtask
  task automatic tTimerOne;
    doSleep();
    t1Req <= 1'b1;
    waitEv(0, 10);
    check(n, 11);
    t1AReq <= 1'b1;
    waitEv(0, 6);
    check(n <= 6, 1);
    {t1Req, t1AReq} <= 2'b00;
    // sleep by register command, then wake from the converter
    axiWrite(WDSW_ADDR_CMD, 32'h01);
    axiRead(WDSW_ADDR_STATUS);
    check(rd[2:0], 3'b110);
    adcReq <= 1'b1;
    waitEv(0, 10);
    check(n, 11);
    adcRcReq <= 1'b1;
    waitEv(0, 6);
    check(n <= 6, 1);
    {adcReq, adcRcReq} <= 2'b00;
  endtask
  task automatic tClear;
    doSleep();
    clearReq <= 1'b1;
    waitEv(3, 8);
    check(n <= 8, 1);
    repeat (4) @(posedge clk);
    clearReq <= 1'b0;
    repeat (8) @(posedge clk);
    axiRead(WDSW_ADDR_STATUS);
    check(rd[2:0], 3'b011);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    tReset();
    tPeriod();
    tConfig();
    tWdWake();
    tIrqWake();
    tPending();
    tTimerOne();
    tClear();
    test_done();
  end
endmodule

// ---- verification/wdsw_core_model.sv ----
// core-side partner model: sleep requests, interrupt sources, master-clear pin
`timescale 1ns/1ns
module wdsw_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // bench requests
  input  wire logic       sleepReq,
  input  wire logic       gieReq,
  input  wire logic       irqReq,
  input  wire logic       t1Req,
  input  wire logic       t1AsyncReq,
  input  wire logic       clearReq,
  input  wire logic       adcReq,
  input  wire logic       adcRcReq,
  // block side
  output logic            sleepExec,
  output logic            globalInterruptEnable,
  output logic [7:0]      irqEnable,
  output logic [7:0]      irqFlag,
  output logic            timerOneAsync,
  output logic            timerOneIrq,
  output logic            adcOnInternalRc,
  output logic            adcDoneIrq,
  output logic            masterClearInput_n
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleepExec             <= 1'b0;
      globalInterruptEnable <= 1'b0;
      irqEnable             <= 8'h00;
      irqFlag               <= 8'h00;
      timerOneAsync         <= 1'b0;
      timerOneIrq           <= 1'b0;
      adcOnInternalRc       <= 1'b0;
      adcDoneIrq            <= 1'b0;
      masterClearInput_n    <= 1'b1;
    end else begin
      // the slot after a sleep is always a no-op, never a second sleep
      sleepExec             <= sleepReq & ~sleepExec;
      globalInterruptEnable <= gieReq;
      irqEnable             <= 8'h01;
      irqFlag               <= {7'h00, irqReq};
      timerOneAsync         <= t1AsyncReq;
      timerOneIrq           <= t1Req;
      adcOnInternalRc       <= adcRcReq;
      adcDoneIrq            <= adcReq;
      // pin stays high unless a scenario asks for a clear
      masterClearInput_n    <= ~clearReq;
    end
  end
endmodule
